/* File: common/emc_map.vh */
// Register map, field positions and fixed figures of the mode control block
`ifndef EMC_MAP_VH
`define EMC_MAP_VH
`define EMC_NUM_REGS      19
`define EMC_IDX_W         5
`define EMC_IDX_CR0       5'h00
`define EMC_IDX_CR1       5'h01
`define EMC_IDX_CR3       5'h03
`define EMC_IDX_LINE      5'h08
`define EMC_IDX_ACOU      5'h09
`define EMC_IDX_LPAD      5'h0a
`define EMC_IDX_APAD      5'h0b
`define EMC_IDX_STAT      5'h12
`define EMC_RESET_VAL     8'h00
`define EMC_CR0_CFG       0
`define EMC_CR1_TBYP      7
`define EMC_CR1_FBYP      5
`define EMC_CR1_MUTE      3
`define EMC_CR1_MLV_HI    2
`define EMC_CR1_MLV_LO    0
`define EMC_CR3_ROUTE_HI  6
`define EMC_CR3_ROUTE_LO  5
`define EMC_CR3_TSLOT     0
`define EMC_CR3_ESLOT_HI  2
`define EMC_CR3_ESLOT_LO  1
`define EMC_CH_BYP        0
`define EMC_CH_CLR1       1
`define EMC_CH_CLR2       2
`define EMC_CH_HOWL       3
`define EMC_CH_CLIP       4
`define EMC_CH_HOLD       5
`define EMC_CH_ATT        6
`define EMC_CH_AGC        7
`define EMC_PAD_OUT_HI    2
`define EMC_PAD_OUT_LO    0
`define EMC_PAD_IN_HI     6
`define EMC_PAD_IN_LO     4
`define EMC_TAIL_SPLIT_MS 6'd27
`define EMC_TAIL_LINE_MS  6'd54
`define EMC_PCM_WORD      4'h8
`define EMC_ADPCM_WORD    4'h4
`define EMC_NIBBLE_WORD   4'h4
`define EMC_CLIP_DBM0     8'hc7
`define EMC_ATT_DB        4'h6
`define EMC_AGC_MAX_DB10  7'h55
`define EMC_AGC_KNEE_DBM0 8'he8
`endif

/* File: verif/emc_host_model.sv */
// Behavioural microcontroller on the parallel host port
`timescale 1ns/10ps
module emc_host_model (
   input  wire       pclk,
   input  wire       host_bus_style,
   output reg        host_cs_n = 1'b1,
   output reg        host_rd_n = 1'b1,
   output reg        host_wr_n = 1'b1,
   output reg  [4:0] host_addr = 5'h00,
   output reg  [7:0] host_data_in = 8'h00,
   input  wire [7:0] host_data_out,
   input  wire       host_data_oe_n
);
   // One byte per strobe; strobe goes idle before the next access
   task wr(input [4:0] idx, input [7:0] d);
      begin
         @(posedge pclk);
         host_cs_n <= 1'b0;
         host_rd_n <= ~host_bus_style;
         host_wr_n <= 1'b0;
         host_addr <= idx;
         host_data_in <= d;
         @(posedge pclk);
         host_cs_n <= 1'b1;
         host_rd_n <= 1'b1;
         host_wr_n <= 1'b1;
         // No pull on released lines: show something wrong
         host_data_in <= ~d;
         @(posedge pclk);
      end
   endtask
   task rd(input [4:0] idx, output [7:0] d, output oe_n);
      begin
         @(posedge pclk);
         host_cs_n <= 1'b0;
         host_rd_n <= 1'b0;
         host_addr <= idx;
         @(posedge pclk);
         @(posedge pclk);
         d = host_data_out;
         oe_n = host_data_oe_n;
         host_cs_n <= 1'b1;
         host_rd_n <= 1'b1;
         @(posedge pclk);
      end
   endtask
endmodule

/* File: verif/emc_mode_ctrl_sva.sv */
// Assertion checker watching the ports of the mode control block
`timescale 1ns/10ps
module emc_mode_ctrl_chk (
   input wire       pclk,
   input wire       presetn,
   input wire       psel,
   input wire       penable,
   input wire       pready,
   input wire       host_cs_n,
   input wire       host_rd_n,
   input wire       host_bus_style,
   input wire       host_data_oe_n,
   input wire       transcoder_bypass,
   input wire       full_bypass,
   input wire       canceller_config,
   input wire       line_bypass,
   input wire       line_coef1_clear_n,
   input wire       acoustic_coef2_clear_n,
   input wire [2:0] mute_level_sel,
   input wire [2:0] line_out_pad,
   input wire       transcoder_active,
   input wire [3:0] adpcm_word_bits,
   input wire [3:0] pcm_word_bits,
   input wire [5:0] line_tail_ms,
   input wire       acoustic_active,
   input wire [1:0] ch_pass,
   input wire [1:0] ch_clr1,
   input wire [1:0] ch_clr2,
   input wire [2:0] mute_level,
   input wire [3:0] line_out_db
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////
   // Zero wait answer, one cycle wide
   property p_apb_ans; psel && !penable |=> pready ##1 !pready; endproperty
   a_apb_ans: assert property (p_apb_ans) else $error("apb answer wrong");
   property p_host_rd;
      !host_cs_n && !host_rd_n && !host_bus_style |=> !host_data_oe_n;
   endproperty
   a_host_rd: assert property (p_host_rd) else $error("host read idle");
   property p_tbyp;
      transcoder_bypass |=> adpcm_word_bits == 4'h8 && !transcoder_active;
   endproperty
   a_tbyp: assert property (p_tbyp) else $error("transcoder bypass");
   property p_fbyp;
      full_bypass |=> pcm_word_bits == 4'h4 && !acoustic_active;
   endproperty
   a_fbyp: assert property (p_fbyp) else $error("full bypass");
   property p_cfg;
      canceller_config |=> line_tail_ms == 6'd54 && !acoustic_active;
   endproperty
   a_cfg: assert property (p_cfg) else $error("canceller config");
   property p_pass; line_bypass |=> ch_pass[0]; endproperty
   a_pass: assert property (p_pass) else $error("line pass");
   property p_clr1; !line_coef1_clear_n |=> ch_clr1[0]; endproperty
   a_clr1: assert property (p_clr1) else $error("line clear one");
   property p_clr2; $fell(acoustic_coef2_clear_n) |=> ch_clr2[1]; endproperty
   a_clr2: assert property (p_clr2) else $error("acoustic clear two");
   property p_mute;
      1 |=> (mute_level & $past(mute_level_sel)) == $past(mute_level_sel);
   endproperty
   a_mute: assert property (p_mute) else $error("mute level");
   property p_pad; 1 |=> line_out_db[3:1] >= $past(line_out_pad); endproperty
   a_pad: assert property (p_pad) else $error("line out pad");
   c_full: cover property (full_bypass ##1 pcm_word_bits == 4'h4);
   c_host: cover property (!host_data_oe_n);
   c_apb: cover property (psel && penable && pready);
endmodule
bind emc_mode_ctrl emc_mode_ctrl_chk chk (.*);

/* File: verif/testbench.sv */
// Self-checking bench of the mode control block
`timescale 1ns/10ps
module testbench;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, host_data_oe_n, host_bus_style = 1'b0;
   logic        host_cs_n, host_rd_n, host_wr_n;
   logic [4:0]  host_addr;
   logic [7:0]  host_data_in, host_data_out, ls = 8'h00, as = 8'h00;
   logic        transcoder_bypass = 1'b0, full_bypass = 1'b0, mute = 1'b0;
   logic        canceller_config = 1'b0;
   logic [1:0]  io_route_sel = 2'h0, io_route, canceller_slot;
   logic [2:0]  mute_level_sel = 3'h0, mute_level;
   logic [2:0]  line_out_pad = 3'h0, acoustic_out_pad = 3'h0;
   logic [2:0]  line_in_loss = 3'h0, acoustic_in_loss = 3'h0;
   logic        reserved_det_a = 1'b0, reserved_det_b = 1'b0;
   logic        reserved_det_c = 1'b0;
   wire         line_bypass, line_coef1_clear_n, line_coef2_clear_n;
   wire         line_howl_detect, line_center_clip, line_coef_hold;
   wire         line_atten_en_n, line_rx_gain_ctl;
   wire         acoustic_bypass, acoustic_coef1_clear_n, acoustic_coef2_clear_n;
   wire         acoustic_howl_detect, acoustic_center_clip, acoustic_coef_hold;
   wire         acoustic_atten_en_n, acoustic_rx_gain_ctl;
   logic        transcoder_active, mute_active, transcoder_slot;
   logic        acoustic_active;
   logic [3:0]  adpcm_word_bits, pcm_word_bits, line_out_db, acoustic_out_db;
   logic [3:0]  line_in_db, acoustic_in_db;
   logic [5:0]  line_tail_ms;
   logic [1:0]  ch_enable, ch_pass, ch_clr1, ch_clr2, ch_howl, ch_clip;
   logic [1:0]  ch_hold, ch_att, ch_agc;
   int          n_fail = 0, checks_done = 0;
   // Bit b of ls/as asserts strap b; active-low ones are inverted here
   assign {line_rx_gain_ctl, line_atten_en_n, line_coef_hold, line_center_clip,
      line_howl_detect, line_coef2_clear_n, line_coef1_clear_n,
      line_bypass} = ls ^ 8'h46;
   assign {acoustic_rx_gain_ctl, acoustic_atten_en_n, acoustic_coef_hold,
      acoustic_center_clip, acoustic_howl_detect, acoustic_coef2_clear_n,
      acoustic_coef1_clear_n, acoustic_bypass} = as ^ 8'h46;
   emc_mode_ctrl dut (.*);
   emc_host_model host (.*);
   always #20 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////////
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // One APB transfer, held until pready
   task apb(input w, input [7:0] a, input [7:0] d, input [7:0] exp, input e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      if (!w)
         chk("read data", prdata, {24'h0, exp});
      chk("slave error", pslverr, e);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task settle;
      repeat (3) @(posedge pclk);
   endtask
   function automatic [7:0] chpack(input int c);
      chpack = {ch_agc[c], ch_att[c], ch_hold[c], ch_clip[c], ch_howl[c],
         ch_clr2[c], ch_clr1[c], ch_pass[c]};
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   task t_regs;
      apb(0, 8'h04, 0, 8'h00, 0);
      apb(1, 8'h08, 8'h5a, 0, 0);
      apb(0, 8'h08, 0, 8'h5a, 0);
      apb(1, 8'h48, 8'hff, 0, 0);
      apb(0, 8'h48, 0, 8'h00, 0);
      apb(1, 8'h4c, 8'h77, 0, 1);
      apb(0, 8'h4c, 0, 8'h00, 1);
      apb(0, 8'h09, 0, 8'h00, 1);
   endtask
   task t_host;
      logic [7:0] d;
      logic       oe_n;
      begin
         host.wr(5'd8, 8'h06);
         apb(0, 8'h20, 0, 8'h06, 0);
         apb(1, 8'h10, 8'h3c, 0, 0);
         host.rd(5'd4, d, oe_n);
         chk("host read", d, 8'h3c);
         chk("host drive", oe_n, 1'b0);
         host.rd(5'd19, d, oe_n);
         chk("host unmapped", d, 8'h00);
         host_bus_style <= 1'b1;
         host.wr(5'd5, 8'h69);
         host.rd(5'd5, d, oe_n);
         chk("shared strobe", d, 8'h69);
         host_bus_style <= 1'b0;
      end
   endtask
   task t_bypass;
      begin
         apb(1, 8'h04, 8'h80, 0, 0);
         settle;
         chk("adpcm bits", adpcm_word_bits, 4'h8);
         chk("codec on", transcoder_active, 1'b0);
         apb(1, 8'h04, 8'h00, 0, 0);
         mute <= 1'b1;
         full_bypass <= 1'b1;
         transcoder_bypass <= 1'b1;
         canceller_config <= 1'b1;
         settle;
         chk("pcm bits", pcm_word_bits, 4'h4);
         chk("mute on", mute_active, 1'b0);
         chk("channels", ch_enable, 2'b00);
         chk("pin tail", line_tail_ms, 6'd54);
         full_bypass <= 1'b0;
         transcoder_bypass <= 1'b0;
         canceller_config <= 1'b0;
         settle;
         chk("mute on", mute_active, 1'b1);
         chk("pcm bits", pcm_word_bits, 4'h8);
         mute <= 1'b0;
      end
   endtask
   task t_mode;
      begin
         apb(1, 8'h00, 8'h01, 0, 0);
         settle;
         chk("tail", line_tail_ms, 6'd54);
         chk("channels", ch_enable, 2'b01);
         apb(1, 8'h00, 8'h00, 0, 0);
         settle;
         chk("tail", line_tail_ms, 6'd27);
         chk("acoustic on", acoustic_active, 1'b1);
      end
   endtask
   // Register bits on one channel, straps on the other
   task t_chan;
      for (int s = 0; s < 2; s++) begin
         for (int b = 0; b < 8; b++) begin
            apb(1, s ? 8'h24 : 8'h20, 8'h01 << b, 0, 0);
            if (s)
               ls <= 8'h01 << b;
            else
               as <= 8'h01 << b;
            settle;
            chk("line ctl", chpack(0), 8'h01 << b);
            chk("acou ctl", chpack(1), 8'h01 << b);
         end
         apb(1, s ? 8'h24 : 8'h20, 8'h00, 0, 0);
         ls <= 8'h00;
         as <= 8'h00;
      end
   endtask
   task t_pads;
      begin
         for (int c = 0; c < 8; c++) begin
            line_out_pad <= c[2:0];
            line_in_loss <= ~c[2:0];
            settle;
            chk("line out", line_out_db, {c[2:0], 1'b0});
            chk("line in", line_in_db, {~c[2:0], 1'b0});
         end
         line_out_pad <= 3'h0;
         line_in_loss <= 3'h0;
         mute_level_sel <= 3'h1;
         io_route_sel <= 2'h1;
         apb(1, 8'h2c, 8'h53, 0, 0);
         apb(1, 8'h04, 8'h04, 0, 0);
         apb(1, 8'h0c, 8'h47, 0, 0);
         settle;
         chk("acou out", acoustic_out_db, 4'h6);
         chk("acou in", acoustic_in_db, 4'ha);
         chk("mute level", mute_level, 3'h5);
         chk("route", io_route, 2'h3);
         chk("codec slot", transcoder_slot, 1'b1);
         chk("canc slot", canceller_slot, 2'h3);
         apb(0, 8'h48, 0, 8'h18, 0);
      end
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      tally_and_finish;
   end
   initial begin
      repeat (3) @(posedge pclk);
      chk("reset pcm", pcm_word_bits, 4'h8);
      chk("reset tail", line_tail_ms, 6'd27);
      chk("reset drive", host_data_oe_n, 1'b1);
      @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_host;
      t_bypass;
      t_mode;
      t_chan;
      t_pads;
      tally_and_finish;
   end
endmodule

/* File: verilog/emc_mode_ctrl.v */
// Mode and configuration control of the dual echo canceller and transcoder
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
// Functional notes
// - Nineteen byte control bank, read by the host port strobes; all but the read-only status byte also written.
// - Host gives register index on host_addr; data lines driven only on reads.
// - Transcoder bypass makes ADPCM serial ports carry 8-bit PCM words.
// - Effective transcoder bypass is strap OR control register 1 bit 7.
// - Full bypass makes PCM ports 4-bit and disables canceller, codec, mute.
// - Effective full bypass is strap OR control register 1 bit 5.
// - Transcoder PCM in slot 1 or 2, canceller slots 1 to 4, ADPCM slot 1.
// - Config 0 gives two 27 ms cancellers; config 1 one 54 ms line canceller.
// - Canceller bypass passes send and receive through, keeping coefficients.
// - Low coefficient-1 clear input resets coefficient set 1 of that canceller.
// - Low coefficient-2 clear input resets coefficient set 2 of that canceller.
// - Howling detect control enables detection when 1, disables when 0.
// - Centre clipping forces send output to minimum code at or below -57 dBm0.
// - Coefficient hold freezes adaptation at 1; normal adaptation at 0.
// - Active-low attenuator enable gives about 6 dB on send or receive path.
// - Receive gain control attenuates 0 to 8.5 dB above -24 dBm0 input.
// - Mute input enables mute level; level select ORed with register bits 2-0.
// - Pad codes 000 to 111 select 0 to 14 dB in 2 dB steps.
// - Two-bit routing select ORed with control register 3 bits 6 and 5.
// - Host bus style 0 uses separate strobes; 1 uses shared read/write control.
`include "emc_map.vh"
module emc_mode_ctrl (
   pclk,
   presetn,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   host_cs_n,
   host_rd_n,
   host_wr_n,
   host_bus_style,
   host_addr,
   host_data_in,
   host_data_out,
   host_data_oe_n,
   transcoder_bypass,
   full_bypass,
   canceller_config,
   io_route_sel,
   mute,
   mute_level_sel,
   line_bypass,
   acoustic_bypass,
   line_coef1_clear_n,
   acoustic_coef1_clear_n,
   line_coef2_clear_n,
   acoustic_coef2_clear_n,
   line_howl_detect,
   acoustic_howl_detect,
   line_center_clip,
   acoustic_center_clip,
   line_coef_hold,
   acoustic_coef_hold,
   line_atten_en_n,
   acoustic_atten_en_n,
   line_rx_gain_ctl,
   acoustic_rx_gain_ctl,
   line_out_pad,
   acoustic_out_pad,
   line_in_loss,
   acoustic_in_loss,
   reserved_det_a,
   reserved_det_b,
   reserved_det_c,
   transcoder_active,
   adpcm_word_bits,
   pcm_word_bits,
   mute_active,
   mute_level,
   io_route,
   transcoder_slot,
   canceller_slot,
   line_tail_ms,
   acoustic_active,
   ch_enable,
   ch_pass,
   ch_clr1,
   ch_clr2,
   ch_howl,
   ch_clip,
   ch_hold,
   ch_att,
   ch_agc,
   line_out_db,
   acoustic_out_db,
   line_in_db,
   acoustic_in_db
);
   parameter AW = 8;
   input  wire          pclk;
   input  wire          presetn;
   input  wire          psel;
   input  wire          penable;
   input  wire          pwrite;
   input  wire [AW-1:0] paddr;
   input  wire [31:0]   pwdata;
   output wire [31:0]   prdata;
   output wire          pready;
   output wire          pslverr;
   input  wire          host_cs_n;
   input  wire          host_rd_n;
   input  wire          host_wr_n;
   input  wire          host_bus_style;
   input  wire [4:0]    host_addr;
   input  wire [7:0]    host_data_in;
   output wire [7:0]    host_data_out;
   output wire          host_data_oe_n;
   input  wire          transcoder_bypass;
   input  wire          full_bypass;
   input  wire          canceller_config;
   input  wire [1:0]    io_route_sel;
   input  wire          mute;
   input  wire [2:0]    mute_level_sel;
   input  wire          line_bypass;
   input  wire          acoustic_bypass;
   input  wire          line_coef1_clear_n;
   input  wire          acoustic_coef1_clear_n;
   input  wire          line_coef2_clear_n;
   input  wire          acoustic_coef2_clear_n;
   input  wire          line_howl_detect;
   input  wire          acoustic_howl_detect;
   input  wire          line_center_clip;
   input  wire          acoustic_center_clip;
   input  wire          line_coef_hold;
   input  wire          acoustic_coef_hold;
   input  wire          line_atten_en_n;
   input  wire          acoustic_atten_en_n;
   input  wire          line_rx_gain_ctl;
   input  wire          acoustic_rx_gain_ctl;
   input  wire [2:0]    line_out_pad;
   input  wire [2:0]    acoustic_out_pad;
   input  wire [2:0]    line_in_loss;
   input  wire [2:0]    acoustic_in_loss;
   input  wire          reserved_det_a;
   input  wire          reserved_det_b;
   input  wire          reserved_det_c;
   output wire          transcoder_active;
   output wire [3:0]    adpcm_word_bits;
   output wire [3:0]    pcm_word_bits;
   output wire          mute_active;
   output wire [2:0]    mute_level;
   output wire [1:0]    io_route;
   output wire          transcoder_slot;
   output wire [1:0]    canceller_slot;
   output wire [5:0]    line_tail_ms;
   output wire          acoustic_active;
   output wire [1:0]    ch_enable;
   output wire [1:0]    ch_pass;
   output wire [1:0]    ch_clr1;
   output wire [1:0]    ch_clr2;
   output wire [1:0]    ch_howl;
   output wire [1:0]    ch_clip;
   output wire [1:0]    ch_hold;
   output wire [1:0]    ch_att;
   output wire [1:0]    ch_agc;
   output wire [3:0]    line_out_db;
   output wire [3:0]    acoustic_out_db;
   output wire [3:0]    line_in_db;
   output wire [3:0]    acoustic_in_db;

   ////////////////////////////////////////////////////////////////////////
   // Register bank
   reg  [7:0]  bank_ff [0:`EMC_NUM_REGS-1];
   reg  [31:0] prdata_ff;
   reg         pready_ff;
   reg         pslverr_ff;
   reg  [7:0]  hdata_ff;
   reg         hoe_n_ff;
   reg         hstrb_ff;
   wire [4:0]  apb_idx;
   wire        apb_hit;
   wire        apb_wr;
   wire        h_sel;
   wire        h_rd;
   wire        h_wr;
   wire        h_wr_edge;
   wire        h_hit;
   wire [7:0]  stat;
   reg  [7:0]  apb_rd_byte;

   // Byte address is four times the register index
   assign apb_idx = paddr[6:2];
   assign apb_hit = (paddr[1:0] == 2'h0) && (paddr[AW-1:7] == 0) &&
                    (apb_idx < `EMC_NUM_REGS);
   assign apb_wr  = psel & penable & pready_ff & pwrite & apb_hit;

   // Host port strobe decoding
   assign h_sel = ~host_cs_n;
   assign h_rd  = host_bus_style ? (h_sel & ~host_rd_n & host_wr_n)
                                 : (h_sel & ~host_rd_n);
   assign h_wr  = host_bus_style ? (h_sel & ~host_rd_n & ~host_wr_n)
                                 : (h_sel & ~host_wr_n);
   assign h_wr_edge = h_wr & ~hstrb_ff;
   assign h_hit = (host_addr < `EMC_NUM_REGS);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hstrb_ff <= 1'b0;
      end else begin
         hstrb_ff <= h_wr;
      end
   end

   // One write per host strobe; the APB write wins a same-cycle clash
   genvar gi;
   generate
      for (gi = 0; gi < `EMC_NUM_REGS; gi = gi + 1) begin : g_bank
         if (gi == `EMC_IDX_STAT) begin : g_ro
            always @* begin
               bank_ff[gi] = stat;
            end
         end else begin : g_rw
            always @(posedge pclk or negedge presetn) begin
               if (!presetn) begin
                  bank_ff[gi] <= `EMC_RESET_VAL;
               end else if (apb_wr && apb_idx == gi) begin
                  bank_ff[gi] <= pwdata[7:0];
               end else if (h_wr_edge && host_addr == gi) begin
                  bank_ff[gi] <= host_data_in;
               end
            end
         end
      end
   endgenerate

   always @* begin
      if (apb_hit) begin
         apb_rd_byte = bank_ff[apb_idx];
      end else begin
         apb_rd_byte = 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave: answer prepared in setup, completes in first access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff  <= 32'h0000_0000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else if (psel && !penable) begin
         prdata_ff  <= {24'h00_0000, apb_rd_byte};
         pready_ff  <= 1'b1;
         pslverr_ff <= ~apb_hit;
      end else begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end
   end

   // Host data lines enabled only while a read is held
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hdata_ff <= 8'h00;
         hoe_n_ff <= 1'b1;
      end else begin
         hdata_ff <= h_hit ? bank_ff[host_addr] : 8'h00;
         hoe_n_ff <= ~h_rd;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Merged global controls
   wire       tbyp_eff;
   wire       fbyp_eff;
   wire       cfg_eff;
   wire [1:0] route_eff;
   wire       mute_eff;
   wire [2:0] mlv_eff;
   assign tbyp_eff  = transcoder_bypass |
                      bank_ff[`EMC_IDX_CR1][`EMC_CR1_TBYP];
   assign fbyp_eff  = full_bypass |
                      bank_ff[`EMC_IDX_CR1][`EMC_CR1_FBYP];
   assign cfg_eff   = canceller_config |
                      bank_ff[`EMC_IDX_CR0][`EMC_CR0_CFG];
   assign route_eff = io_route_sel | bank_ff[`EMC_IDX_CR3]
                      [`EMC_CR3_ROUTE_HI:`EMC_CR3_ROUTE_LO];
   assign mute_eff  = mute | bank_ff[`EMC_IDX_CR1][`EMC_CR1_MUTE];
   assign mlv_eff   = mute_level_sel | bank_ff[`EMC_IDX_CR1]
                      [`EMC_CR1_MLV_HI:`EMC_CR1_MLV_LO];
   assign stat = {fbyp_eff, tbyp_eff, cfg_eff, route_eff, mute_eff, 2'h0};

   reg        tact_ff;
   reg  [3:0] abits_ff;
   reg  [3:0] pbits_ff;
   reg        mact_ff;
   reg  [2:0] mlv_ff;
   reg  [1:0] route_ff;
   reg        tslot_ff;
   reg  [1:0] eslot_ff;
   reg  [5:0] tail_ff;
   reg        aact_ff;

   // Reserved detection inputs are not used in any decision
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tact_ff  <= 1'b0;
         abits_ff <= `EMC_ADPCM_WORD;
         pbits_ff <= `EMC_PCM_WORD;
         mact_ff  <= 1'b0;
         mlv_ff   <= 3'h0;
         route_ff <= 2'h0;
         tslot_ff <= 1'b0;
         eslot_ff <= 2'h0;
         tail_ff  <= `EMC_TAIL_SPLIT_MS;
         aact_ff  <= 1'b0;
      end else begin
         tact_ff  <= ~tbyp_eff & ~fbyp_eff;
         abits_ff <= tbyp_eff ? `EMC_PCM_WORD : `EMC_ADPCM_WORD;
         pbits_ff <= fbyp_eff ? `EMC_NIBBLE_WORD : `EMC_PCM_WORD;
         mact_ff  <= mute_eff & ~fbyp_eff;
         mlv_ff   <= mlv_eff;
         route_ff <= route_eff;
         // Slot codes are slot number minus one; ADPCM stays in slot 1
         tslot_ff <= bank_ff[`EMC_IDX_CR3][`EMC_CR3_TSLOT];
         eslot_ff <= bank_ff[`EMC_IDX_CR3]
                     [`EMC_CR3_ESLOT_HI:`EMC_CR3_ESLOT_LO];
         tail_ff  <= cfg_eff ? `EMC_TAIL_LINE_MS
                             : `EMC_TAIL_SPLIT_MS;
         aact_ff  <= ~cfg_eff & ~fbyp_eff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-canceller controls: channel 0 line, channel 1 acoustic
   wire [1:0] p_byp;
   wire [1:0] p_c1_n;
   wire [1:0] p_c2_n;
   wire [1:0] p_howl;
   wire [1:0] p_clip;
   wire [1:0] p_hold;
   wire [1:0] p_att_n;
   wire [1:0] p_agc;
   wire [5:0] p_opad;
   wire [5:0] p_ipad;
   reg  [1:0] en_ff;
   reg  [1:0] pass_ff;
   reg  [1:0] clr1_ff;
   reg  [1:0] clr2_ff;
   reg  [1:0] howl_ff;
   reg  [1:0] clip_ff;
   reg  [1:0] hold_ff;
   reg  [1:0] att_ff;
   reg  [1:0] agc_ff;
   reg  [7:0] odb_ff;
   reg  [7:0] idb_ff;
   assign p_byp   = {acoustic_bypass, line_bypass};
   assign p_c1_n  = {acoustic_coef1_clear_n, line_coef1_clear_n};
   assign p_c2_n  = {acoustic_coef2_clear_n, line_coef2_clear_n};
   assign p_howl  = {acoustic_howl_detect, line_howl_detect};
   assign p_clip  = {acoustic_center_clip, line_center_clip};
   assign p_hold  = {acoustic_coef_hold, line_coef_hold};
   assign p_att_n = {acoustic_atten_en_n, line_atten_en_n};
   assign p_agc   = {acoustic_rx_gain_ctl, line_rx_gain_ctl};
   assign p_opad  = {acoustic_out_pad, line_out_pad};
   assign p_ipad  = {acoustic_in_loss, line_in_loss};

   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
         wire [7:0] cr;
         wire [7:0] pad;
         wire [2:0] opad;
         wire [2:0] ipad;
         assign cr   = bank_ff[`EMC_IDX_LINE + gi];
         assign pad  = bank_ff[`EMC_IDX_LPAD + gi];
         assign opad = p_opad[gi*3+2:gi*3] |
                       pad[`EMC_PAD_OUT_HI:`EMC_PAD_OUT_LO];
         assign ipad = p_ipad[gi*3+2:gi*3] |
                       pad[`EMC_PAD_IN_HI:`EMC_PAD_IN_LO];
         // Clear and attenuator registers are active high, straps low
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               en_ff[gi]         <= 1'b0;
               pass_ff[gi]       <= 1'b0;
               clr1_ff[gi]       <= 1'b0;
               clr2_ff[gi]       <= 1'b0;
               howl_ff[gi]       <= 1'b0;
               clip_ff[gi]       <= 1'b0;
               hold_ff[gi]       <= 1'b0;
               att_ff[gi]        <= 1'b0;
               agc_ff[gi]        <= 1'b0;
               odb_ff[gi*4+3:gi*4] <= 4'h0;
               idb_ff[gi*4+3:gi*4] <= 4'h0;
            end else begin
               en_ff[gi]   <= ~fbyp_eff &
                              ((gi == 0) | ~cfg_eff);
               // Pass-through leaves coefficients alone, so no clear here
               pass_ff[gi] <= p_byp[gi] | cr[`EMC_CH_BYP];
               clr1_ff[gi] <= ~p_c1_n[gi] | cr[`EMC_CH_CLR1];
               clr2_ff[gi] <= ~p_c2_n[gi] | cr[`EMC_CH_CLR2];
               howl_ff[gi] <= p_howl[gi] | cr[`EMC_CH_HOWL];
               clip_ff[gi] <= p_clip[gi] | cr[`EMC_CH_CLIP];
               hold_ff[gi] <= p_hold[gi] | cr[`EMC_CH_HOLD];
               att_ff[gi]  <= ~p_att_n[gi] | cr[`EMC_CH_ATT];
               agc_ff[gi]  <= p_agc[gi] | cr[`EMC_CH_AGC];
               odb_ff[gi*4+3:gi*4] <= {opad, 1'b0};
               idb_ff[gi*4+3:gi*4] <= {ipad, 1'b0};
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign prdata          = prdata_ff;
   assign pready          = pready_ff;
   assign pslverr         = pslverr_ff;
   assign host_data_out   = hdata_ff;
   assign host_data_oe_n  = hoe_n_ff;
   assign transcoder_active = tact_ff;
   assign adpcm_word_bits = abits_ff;
   assign pcm_word_bits   = pbits_ff;
   assign mute_active     = mact_ff;
   assign mute_level      = mlv_ff;
   assign io_route        = route_ff;
   assign transcoder_slot = tslot_ff;
   assign canceller_slot  = eslot_ff;
   assign line_tail_ms    = tail_ff;
   assign acoustic_active = aact_ff;
   assign ch_enable       = en_ff;
   assign ch_pass         = pass_ff;
   assign ch_clr1         = clr1_ff;
   assign ch_clr2         = clr2_ff;
   assign ch_howl         = howl_ff;
   assign ch_clip         = clip_ff;
   assign ch_hold         = hold_ff;
   assign ch_att          = att_ff;
   assign ch_agc          = agc_ff;
   assign line_out_db     = odb_ff[3:0];
   assign acoustic_out_db = odb_ff[7:4];
   assign line_in_db      = idb_ff[3:0];
   assign acoustic_in_db  = idb_ff[7:4];
endmodule
